// File: core/event_latch.sv
// one sticky status flag, set by a level or a rising edge
// assumes the clear is a one-cycle pulse in the same clock domain
`timescale 1ns/10ps
module event_latch #(
   parameter bit EDGE = 1'b0
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   // event and clear
   input  wire logic i_cond,
   input  wire logic i_clear,
   // flag
   output logic      o_flag
);
   logic cond_q;
   logic set;

   assign set = EDGE ? (i_cond & ~cond_q) : i_cond;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cond_q <= 1'b0;
         o_flag <= 1'b0;
      end else begin
         cond_q <= i_cond;
         // set wins so an event in the clear cycle survives
         o_flag <= set | (o_flag & ~i_clear);
      end
   end
endmodule : event_latch

// File: core/tec_ctrl.sv
// serial register bank, status latches and protection sequencer
// assumes scl, sda and comparator levels are synchronous to i_clk
//
// Functional notes
// - after hiccup off, terminals low, stage runs 1 ms check at 0.4 V
// - clean check starts soft-start; fault or short starts another 15 ms off
// - supply over-voltage turns both terminals off and discharges them
// - supply back below restart threshold launches a new soft-start
// - over-temperature stops the stage; recovery restarts automatically
// - seven byte registers, accessible regardless of enable and shutdown pins
// - slave address 0x60 with floating strap, 0x21 with strap pulled low
// - two-bit soft-start field picks 15, 30, 60 or 120 ms, reset 120
// - writing refresh clears latched status; the bit reads back zero
// - stage runs only with software enable, enable pin, shutdown pin high
// - current setpoints in registers 1 and 2 act only when enabled
// - voltage setpoints in registers 3 and 4 act only when enabled
// - exceeded enabled limit holds switching leg instead of analog setpoint
// - register 5 selects four secondary trips; short trip enters hiccup
// - direction field reads 10 heating, 01 cooling, 00 near boundary
// - voltage limit event bit sticks until refresh
// - current limit event bit latches on rising condition until refresh
// - over-temperature bit latches until refresh
// - thermal warning bit latches until refresh
// - hiccup on leg trips or second voltage limit; 15 ms off then check
// - soft-start discharges 30 or 60 ms until low, then two ramp stages
// - switching leg trip must persist 100 us before hiccup
`timescale 1ns/10ps
module tec_ctrl #(
   parameter int P_MS_US = tec_ctrl_pkg::MS_US
) (
   // clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_b,
   // serial bus, open drain data
   input  wire logic                        i_scl,
   input  wire logic                        i_sda,
   output logic                             o_sda_out,
   output logic                             o_sda_oe,
   // pins and comparators
   input  wire logic                        i_addr_strap_low,
   input  wire logic                        i_enable_pin,
   input  wire logic                        i_shutdown_pin,
   input  wire tec_ctrl_pkg::sense_s        i_sense,
   // power stage control
   output logic                             o_stage_on,
   output logic                             o_discharge,
   output logic                             o_check_regulate,
   output logic                             o_ramp_common,
   output logic                             o_ramp_split,
   output logic                             o_limit_hold,
   output tec_ctrl_pkg::analog_cfg_s        o_cfg
);
   import tec_ctrl_pkg::*;

   typedef enum logic [3:0] {
      ST_OFF, ST_DISCHARGE, ST_RAMP_COMMON, ST_RAMP_SPLIT, ST_RUN,
      ST_HICCUP_OFF, ST_CHECK, ST_OVP_OFF, ST_OT_OFF
   } seq_e;

   typedef enum logic [2:0] {
      I_IDLE, I_START, I_ADDR, I_ADDR_ACK, I_WR, I_WR_ACK, I_RD, I_RD_ACK
   } bus_e;

   ////////////////////////////////////////////////////////////////////////////
   // tick dividers, free running
   logic [6:0] us_cnt;
   logic [9:0] ms_sub;
   logic       us_tick;
   logic       ms_tick;

   assign us_tick = (us_cnt == 7'(US_CYC - 1));
   assign ms_tick = us_tick & (ms_sub == 10'(P_MS_US - 1));

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         us_cnt <= 7'h00;
         ms_sub <= 10'h000;
      end else begin
         us_cnt <= us_tick ? 7'h00 : us_cnt + 7'h01;
         if (us_tick) begin
            ms_sub <= (ms_sub == 10'(P_MS_US - 1)) ? 10'h000 : ms_sub + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address strap, followed for 20 ms after reset then frozen
   logic [4:0] strap_cnt;
   logic [6:0] slave_addr;
   logic       strap_open;

   assign strap_open = (strap_cnt != 5'(STRAP_MS));

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         strap_cnt  <= 5'h00;
         slave_addr <= ADDR_FLOAT;
      end else if (strap_open) begin
         if (ms_tick) begin
            strap_cnt <= strap_cnt + 5'h01;
         end
         slave_addr <= i_addr_strap_low ? ADDR_STRAP_LOW : ADDR_FLOAT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial slave
   bus_e       bus_st;
   logic       scl_q;
   logic       sda_q;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] rd_sh;
   logic [7:0] ptr;
   logic       rw;
   logic       first;
   logic       nack;
   logic [7:0] rd_data;
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic       wr_fire;
   logic       last_bit;

   assign scl_rise  = i_scl & ~scl_q;
   assign scl_fall  = ~i_scl & scl_q;
   assign bus_start = i_scl & scl_q & sda_q & ~i_sda;
   assign bus_stop  = i_scl & scl_q & ~sda_q & i_sda;
   assign last_bit  = (bit_cnt == 3'h7);
   assign wr_fire   = scl_fall & (bus_st == I_WR) & last_bit & ~first;
   assign o_sda_out = 1'b0;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         bus_st   <= I_IDLE;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         bit_cnt  <= 3'h0;
         shift    <= 8'h00;
         rd_sh    <= 8'h00;
         ptr      <= 8'h00;
         rw       <= 1'b0;
         first    <= 1'b0;
         nack     <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
         if (bus_start) begin
            // the scl fall that closes the start is not a data bit
            bus_st   <= I_START;
            bit_cnt  <= 3'h0;
            o_sda_oe <= 1'b0;
         end else if (bus_stop) begin
            bus_st   <= I_IDLE;
            o_sda_oe <= 1'b0;
         end else if (scl_rise) begin
            shift <= {shift[6:0], i_sda};
            nack  <= i_sda;
         end else if (scl_fall) begin
            case (bus_st)
               I_START: bus_st <= I_ADDR;
               I_ADDR: begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (last_bit) begin
                     if (shift[7:1] == slave_addr) begin
                        bus_st   <= I_ADDR_ACK;
                        rw       <= shift[0];
                        o_sda_oe <= 1'b1;
                     end else begin
                        bus_st <= I_IDLE;
                     end
                  end
               end
               I_ADDR_ACK, I_RD_ACK: begin
                  bit_cnt <= 3'h0;
                  if (bus_st == I_RD_ACK && nack) begin
                     bus_st   <= I_IDLE;
                     o_sda_oe <= 1'b0;
                  end else if (bus_st == I_RD_ACK || rw) begin
                     bus_st   <= I_RD;
                     rd_sh    <= rd_data;
                     o_sda_oe <= ~rd_data[7];
                  end else begin
                     bus_st   <= I_WR;
                     first    <= 1'b1;
                     o_sda_oe <= 1'b0;
                  end
               end
               I_WR: begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (last_bit) begin
                     bus_st   <= I_WR_ACK;
                     o_sda_oe <= 1'b1;
                     first    <= 1'b0;
                     ptr      <= first ? shift : ptr + 8'h01;
                  end
               end
               I_WR_ACK: begin
                  bus_st   <= I_WR;
                  bit_cnt  <= 3'h0;
                  o_sda_oe <= 1'b0;
               end
               I_RD: begin
                  bit_cnt <= bit_cnt + 3'h1;
                  rd_sh   <= {rd_sh[6:0], 1'b0};
                  if (last_bit) begin
                     bus_st   <= I_RD_ACK;
                     o_sda_oe <= 1'b0;
                     ptr      <= ptr + 8'h01;
                  end else begin
                     o_sda_oe <= ~rd_sh[6];
                  end
               end
               default: bus_st <= I_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file, alive whatever the enable pins do
   logic       sw_on;
   logic       mon_sel;
   logic       disch_long;
   logic [1:0] ss_sel;
   logic [7:0] heat_curr;
   logic [7:0] cool_curr;
   logic [7:0] heat_volt;
   logic [7:0] cool_volt;
   logic [7:0] secondary;
   logic       refresh;

   assign refresh = wr_fire & (ptr == OFF_CONTROL) & shift[CTL_REFRESH];

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sw_on      <= RST_SW_ON;
         mon_sel    <= RST_MON_SEL;
         disch_long <= RST_DISCH_LONG;
         ss_sel     <= RST_SS_SEL;
         heat_curr  <= RST_LIMIT;
         cool_curr  <= RST_LIMIT;
         heat_volt  <= RST_LIMIT;
         cool_volt  <= RST_LIMIT;
         secondary  <= RST_SECONDARY;
      end else if (wr_fire) begin
         if (ptr == OFF_CONTROL) begin
            sw_on      <= shift[CTL_SW_ON];
            mon_sel    <= shift[CTL_MON_SEL];
            disch_long <= shift[CTL_DISCH_LONG];
            ss_sel     <= shift[CTL_SS_HI:CTL_SS_LO];
         end
         if (ptr == OFF_HEAT_CURR) heat_curr <= shift;
         if (ptr == OFF_COOL_CURR) cool_curr <= shift;
         if (ptr == OFF_HEAT_VOLT) heat_volt <= shift;
         if (ptr == OFF_COOL_VOLT) cool_volt <= shift;
         if (ptr == OFF_SECONDARY) secondary <= shift;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status
   logic [1:0] mode;
   logic       voltage_limit_event_flag;
   logic       current_limit_event_flag;
   logic       ot_flag;
   logic       otw_flag;
   logic       power_good;
   logic [7:0] ctrl_rd;
   logic [7:0] status_rd;

   assign mode = {i_sense.heating & ~i_sense.cooling,
                  i_sense.cooling & ~i_sense.heating};

   event_latch #(.EDGE(1'b0)) u_voltage_limit_event (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_cond  (i_sense.voltage_limit | i_sense.voltage_limit2),
      .i_clear (refresh),
      .o_flag  (voltage_limit_event_flag)
   );
   event_latch #(.EDGE(1'b1)) u_current_limit_event (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_cond  (i_sense.current_limit),
      .i_clear (refresh),
      .o_flag  (current_limit_event_flag)
   );
   event_latch #(.EDGE(1'b0)) u_ot (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_cond  (i_sense.temp_shutdown),
      .i_clear (refresh),
      .o_flag  (ot_flag)
   );
   event_latch #(.EDGE(1'b0)) u_otw (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_cond  (i_sense.temp_warning),
      .i_clear (refresh),
      .o_flag  (otw_flag)
   );

   // refresh is a write strobe only, so its bit always reads zero
   assign ctrl_rd   = {sw_on, mon_sel, 1'b0, disch_long, ss_sel, 2'b00};
   assign status_rd = {mode, voltage_limit_event_flag, current_limit_event_flag, power_good, 1'b0, ot_flag, otw_flag};
   assign rd_data   = (ptr == OFF_CONTROL)   ? ctrl_rd   :
                      (ptr == OFF_HEAT_CURR) ? heat_curr :
                      (ptr == OFF_COOL_CURR) ? cool_curr :
                      (ptr == OFF_HEAT_VOLT) ? heat_volt :
                      (ptr == OFF_COOL_VOLT) ? cool_volt :
                      (ptr == OFF_SECONDARY) ? secondary :
                      (ptr == OFF_STATUS)    ? status_rd : 8'h00;

   assign o_cfg = '{heat_current: '{heat_curr[LIM_ON], heat_curr[LIM_SET_HI:0]},
                    cool_current: '{cool_curr[LIM_ON], cool_curr[LIM_SET_HI:0]},
                    heat_voltage: '{heat_volt[LIM_ON], heat_volt[LIM_SET_HI:0]},
                    cool_voltage: '{cool_volt[LIM_ON], cool_volt[LIM_SET_HI:0]},
                    linear_leg_heat_trip: secondary[1:0],
                    linear_leg_cool_trip: secondary[3:2],
                    switch_leg_heat_trip: secondary[5:4],
                    switch_leg_cool_trip: secondary[7:6],
                    monitor_current: mon_sel};

   ////////////////////////////////////////////////////////////////////////////
   // protection sequencer
   seq_e       seq_st;
   seq_e       next_seq_st;
   logic       restart;
   logic [7:0] ms_cnt;
   logic [7:0] target;
   logic [7:0] ss_total;
   logic [7:0] ss_stage1;
   logic [6:0] conf_cnt;
   logic       switch_fault;
   logic       fault;
   logic       enabled;
   logic       done;

   assign enabled   = sw_on & i_enable_pin & i_shutdown_pin;
   assign ss_total  = (ss_sel == 2'h0) ? 8'(SS_15_MS) :
                      (ss_sel == 2'h1) ? 8'(SS_30_MS) :
                      (ss_sel == 2'h2) ? 8'(SS_60_MS) : 8'(SS_120_MS);
   assign ss_stage1 = 8'((16'(ss_total) * 16'(SS_STAGE1_NUM)) / 16'(SS_STAGE1_DEN));
   assign target    = (seq_st == ST_DISCHARGE)   ? (disch_long ? 8'(DISCH_LONG_MS)
                                                               : 8'(DISCH_SHORT_MS)) :
                      (seq_st == ST_RAMP_COMMON) ? ss_stage1 :
                      (seq_st == ST_RAMP_SPLIT)  ? ss_total - ss_stage1 :
                      (seq_st == ST_HICCUP_OFF)  ? 8'(HICCUP_OFF_MS) : 8'(CHECK_MS);
   // counting whole ticks from entry keeps every interval at least its length
   assign done      = ms_tick & (ms_cnt == target);
   assign switch_fault = (conf_cnt == 7'(CONFIRM_US));
   assign fault     = o_stage_on & (i_sense.linear_leg_trip2 | i_sense.voltage_limit2
                      | switch_fault);
   assign power_good = (seq_st == ST_RAMP_SPLIT) | (seq_st == ST_RUN);

   always_comb begin
      next_seq_st = seq_st;
      restart     = 1'b0;
      if (!enabled) begin
         next_seq_st = ST_OFF;
      end else if (i_sense.temp_shutdown) begin
         next_seq_st = ST_OT_OFF;
      end else if (i_sense.vin_over) begin
         next_seq_st = ST_OVP_OFF;
      end else begin
         case (seq_st)
            ST_OFF:        next_seq_st = ST_DISCHARGE;
            ST_OT_OFF:     next_seq_st = ST_DISCHARGE;
            ST_OVP_OFF:    if (i_sense.vin_restart) next_seq_st = ST_DISCHARGE;
            ST_DISCHARGE:  if (done) begin
               if (i_sense.terminals_low) next_seq_st = ST_RAMP_COMMON;
               else restart = 1'b1;
            end
            ST_RAMP_COMMON: if (fault) next_seq_st = ST_HICCUP_OFF;
                            else if (done) next_seq_st = ST_RAMP_SPLIT;
            ST_RAMP_SPLIT: if (fault) next_seq_st = ST_HICCUP_OFF;
                           else if (done) next_seq_st = ST_RUN;
            ST_RUN:        if (fault) next_seq_st = ST_HICCUP_OFF;
            ST_HICCUP_OFF: if (done) begin
               if (i_sense.terminals_low) next_seq_st = ST_CHECK;
               else restart = 1'b1;
            end
            ST_CHECK: if (fault | i_sense.ground_short) next_seq_st = ST_HICCUP_OFF;
                      else if (done) next_seq_st = ST_DISCHARGE;
            default:       next_seq_st = ST_OFF;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         seq_st   <= ST_OFF;
         ms_cnt   <= 8'h00;
         conf_cnt <= 7'h00;
      end else begin
         seq_st <= next_seq_st;
         if (restart || next_seq_st != seq_st) begin
            ms_cnt <= 8'h00;
         end else if (ms_tick) begin
            ms_cnt <= ms_cnt + 8'h01;
         end
         // a trip that clears inside the window leaves the stage running
         if (!i_sense.switch_leg_trip || !o_stage_on) begin
            conf_cnt <= 7'h00;
         end else if (us_tick && !switch_fault) begin
            conf_cnt <= conf_cnt + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stage outputs
   logic hold_hit;

   assign o_stage_on       = (seq_st == ST_RAMP_COMMON) | (seq_st == ST_RAMP_SPLIT)
                           | (seq_st == ST_RUN) | (seq_st == ST_CHECK);
   assign o_discharge      = ~o_stage_on;
   assign o_check_regulate = (seq_st == ST_CHECK);
   assign o_ramp_common    = (seq_st == ST_RAMP_COMMON);
   assign o_ramp_split     = (seq_st == ST_RAMP_SPLIT);
   assign hold_hit = i_sense.heating
      ? (i_sense.current_limit & heat_curr[LIM_ON]) | (i_sense.voltage_limit & heat_volt[LIM_ON])
      : (i_sense.current_limit & cool_curr[LIM_ON]) | (i_sense.voltage_limit & cool_volt[LIM_ON]);

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_limit_hold <= 1'b0;
      end else begin
         o_limit_hold <= hold_hit & o_stage_on;
      end
   end
endmodule : tec_ctrl

// File: core/tec_ctrl_pkg.sv
// shared constants and carriers for the cooler driver control logic
// assumes a single 100 MHz system clock and synchronous comparator inputs
package tec_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_HZ        = 100_000_000;
   localparam int US_CYC        = CLK_HZ / 1_000_000;
   localparam int MS_US         = 1000;
   localparam int HICCUP_OFF_MS = 15;
   localparam int CHECK_MS      = 1;
   localparam int CONFIRM_US    = 100;
   localparam int DISCH_SHORT_MS = 30;
   localparam int DISCH_LONG_MS = 60;
   localparam int STRAP_MS      = 20;
   localparam int SS_15_MS      = 15;
   localparam int SS_30_MS      = 30;
   localparam int SS_60_MS      = 60;
   localparam int SS_120_MS     = 120;
   localparam int SS_STAGE1_NUM = 11;
   localparam int SS_STAGE1_DEN = 19;

   ////////////////////////////////////////////////////////////////////////////
   // serial slave addresses
   localparam logic [6:0] ADDR_FLOAT     = 7'h60;
   localparam logic [6:0] ADDR_STRAP_LOW = 7'h21;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] OFF_CONTROL     = 8'h00;
   localparam logic [7:0] OFF_HEAT_CURR   = 8'h01;
   localparam logic [7:0] OFF_COOL_CURR   = 8'h02;
   localparam logic [7:0] OFF_HEAT_VOLT   = 8'h03;
   localparam logic [7:0] OFF_COOL_VOLT   = 8'h04;
   localparam logic [7:0] OFF_SECONDARY   = 8'h05;
   localparam logic [7:0] OFF_STATUS      = 8'h09;

   ////////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int CTL_SW_ON      = 7;
   localparam int CTL_MON_SEL    = 6;
   localparam int CTL_DISCH_LONG = 4;
   localparam int CTL_SS_HI      = 3;
   localparam int CTL_SS_LO      = 2;
   localparam int CTL_REFRESH    = 1;
   // limit register fields
   localparam int LIM_ON         = 7;
   localparam int LIM_SET_HI     = 5;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic       RST_SW_ON      = 1'b1;
   localparam logic       RST_MON_SEL    = 1'b0;
   localparam logic       RST_DISCH_LONG = 1'b0;
   localparam logic [1:0] RST_SS_SEL     = 2'h3;
   localparam logic [7:0] RST_LIMIT      = 8'h3f;
   localparam logic [7:0] RST_SECONDARY  = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic       on;
      logic [5:0] setpoint;
   } limit_s;

   typedef struct packed {
      limit_s     heat_current;
      limit_s     cool_current;
      limit_s     heat_voltage;
      limit_s     cool_voltage;
      logic [1:0] linear_leg_heat_trip;
      logic [1:0] linear_leg_cool_trip;
      logic [1:0] switch_leg_heat_trip;
      logic [1:0] switch_leg_cool_trip;
      logic       monitor_current;
   } analog_cfg_s;

   typedef struct packed {
      logic vin_over;         // supply above upper threshold
      logic vin_restart;      // supply back below restart threshold
      logic temp_shutdown;    // junction above shutdown, hysteresis outside
      logic temp_warning;
      logic terminals_low;    // both terminals below 0.4 V
      logic ground_short;     // short seen during the check window
      logic linear_leg_trip2; // linear leg second current limit
      logic switch_leg_trip;  // switching leg current limit
      logic voltage_limit;    // primary voltage limit reached
      logic voltage_limit2;   // secondary voltage limit reached
      logic current_limit;    // primary current limit reached
      logic heating;
      logic cooling;
   } sense_s;

endpackage : tec_ctrl_pkg

// File: tb/i2c_host.sv
// serial bus host model: start, stop, byte transfers
// assumes sda is wired-and with a pull-up outside
`timescale 1ns/10ps
module i2c_host (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_pull
);
   initial begin
      o_scl = 1;
      o_pull = 0;
   end
   task automatic cyc(input int n); repeat (n) @(posedge i_clk); #1; endtask : cyc
   // sda moves one clock into scl low, never on the fall
   task automatic bit_io(input logic b, output logic r);
      cyc(1); o_pull = ~b; cyc(4); o_scl = 1; cyc(5); r = i_sda; o_scl = 0;
   endtask : bit_io
   task automatic start; cyc(1); o_pull = 0; cyc(4); o_scl = 1; cyc(5); o_pull = 1; cyc(5);
      o_scl = 0; endtask : start
   task automatic stop; cyc(1); o_pull = 1; cyc(4); o_scl = 1; cyc(5); o_pull = 0; cyc(5);
   endtask : stop
   task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, a);
   endtask : xb
   task automatic wr(input logic [6:0] adr, input logic [7:0] p, d, output logic a);
      logic [7:0] q;
      logic a1, a2, a3;
      start; xb({adr, 1'b0}, q, a1); xb(p, q, a2); xb(d, q, a3); stop;
      a = a1 | a2 | a3;
   endtask : wr
   task automatic rd(input logic [7:0] p, output logic [7:0] q);
      logic a;
      start; xb(8'hc0, q, a); xb(p, q, a); start; xb(8'hc1, q, a); xb(8'hff, q, a); stop;
   endtask : rd
endmodule : i2c_host

// File: tb/tec_ctrl_asserts.sv
// port-level checks of the cooler control block
// assumes it is bound to every tec_ctrl instance
`timescale 1ns/10ps
module tec_ctrl_asserts (
   input wire logic                 i_clk, i_rst_b, i_enable_pin, i_shutdown_pin, o_sda_oe,
   input wire tec_ctrl_pkg::sense_s i_sense,
   input wire logic                 o_stage_on, o_discharge, o_check_regulate,
   input wire logic                 o_ramp_common, o_ramp_split, o_limit_hold
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   AST_DISCH: assert property (o_discharge != o_stage_on)
      else $error("discharge and stage overlap");
   AST_EN_OFF: assert property (!(i_enable_pin && i_shutdown_pin) |=> !o_stage_on)
      else $error("stage on while disabled");
   AST_OT_OFF: assert property (i_sense.temp_shutdown |=> !o_stage_on)
      else $error("stage on in thermal stop");
   AST_OVP_OFF: assert property (i_sense.vin_over |=> !o_stage_on)
      else $error("stage on in supply overvoltage");
   AST_HICCUP: assert property (i_sense.linear_leg_trip2 && o_stage_on |=> !o_stage_on)
      else $error("stage kept on after leg trip");
   AST_CHECK_ON: assert property (o_check_regulate |-> o_stage_on)
      else $error("check window without stage");
   AST_RAMP_LOW: assert property ($rose(o_ramp_common) |-> $past(i_sense.terminals_low))
      else $error("ramp began with terminals high");
   AST_SPLIT: assert property ($rose(o_ramp_split) |-> $past(o_ramp_common))
      else $error("split ramp skipped common ramp");
   AST_HOLD: assert property (o_limit_hold |-> $past(o_stage_on))
      else $error("limit hold with stage off");
   // main paths: split ramp, bus ack, stage drop
   cover property (o_ramp_split);
   cover property ($rose(o_sda_oe));
   cover property ($fell(o_stage_on));
endmodule : tec_ctrl_asserts

bind tec_ctrl tec_ctrl_asserts tec_ctrl_asserts_i (.i_clk, .i_rst_b, .i_enable_pin,
   .i_shutdown_pin, .o_sda_oe, .i_sense, .o_stage_on, .o_discharge, .o_check_regulate,
   .o_ramp_common, .o_ramp_split, .o_limit_hold);

// File: tb/testbench.sv
// register, start-up and protection tests through the serial bus
// assumes the ms tick is shortened to 200 clocks
`timescale 1ns/10ps
module testbench;
   import tec_ctrl_pkg::*;
   logic        i_clk = 0, i_rst_b = 0, en = 0, sdn = 1, scl, pull, oe, a, stage_on, check_on;
   wire         sda = ~(pull | oe);
   sense_s      sense = '0;
   analog_cfg_s cfg;
   int          n_errors = 0, samples_checked = 0, cycles = 0;
   tec_ctrl #(.P_MS_US(2)) tec_ctrl_i (.i_clk, .i_rst_b, .i_scl(scl), .i_sda(sda),
      .o_sda_out(), .o_sda_oe(oe), .i_addr_strap_low(1'b0), .i_enable_pin(en),
      .i_shutdown_pin(sdn), .i_sense(sense), .o_stage_on(stage_on), .o_discharge(),
      .o_check_regulate(check_on), .o_ramp_common(), .o_ramp_split(), .o_limit_hold(),
      .o_cfg(cfg));
   i2c_host i2c_host_i (.i_clk, .i_sda(sda), .o_scl(scl), .o_pull(pull));
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) if (++cycles == 70000) begin n_errors++; end_sim(); end
   task automatic tick(input int n); repeat (n) @(posedge i_clk); #1; endtask : tick
   task automatic chk(input string n, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin n_errors++; $display("[FAIL] %s expected %h seen %h", n, e, g); end
   endtask : chk
   task automatic wr(input logic [7:0] p, d);
      i2c_host_i.wr(ADDR_FLOAT, p, d, a); chk("ack", 8'h00, a);
   endtask : wr
   task automatic rd(input string n, input logic [7:0] p, e);
      logic [7:0] q;
      i2c_host_i.rd(p, q); chk(n, e, q);
   endtask : rd
   task automatic wait_on(input logic v);
      for (int k = 0; k < 12000 && stage_on !== v; k++) tick(1);
      chk("stage", v, stage_on);
   endtask : wait_on
   task automatic end_sim;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(20); i_rst_b = 1; sense.terminals_low = 1;
      chk("heat limit cfg", RST_LIMIT, cfg.heat_current);
      tick(4100);
      rd("control", OFF_CONTROL, 8'h8c);
      rd("heat limit", OFF_HEAT_CURR, RST_LIMIT);
      rd("unmapped", 8'h07, 8'h00);
      wr(OFF_HEAT_VOLT, 8'h85); chk("volt cfg", 8'h45, cfg.heat_voltage);
      i2c_host_i.wr(ADDR_STRAP_LOW, OFF_SECONDARY, 8'hff, a); chk("nack", 8'h01, a);
      rd("secondary", OFF_SECONDARY, 8'h00);
      rd("status off", OFF_STATUS, 8'h00);
      wr(OFF_CONTROL, 8'h80); sense.heating = 1; en = 1;
      wait_on(1); tick(1800);
      rd("status run", OFF_STATUS, 8'h88);
      // events and thermal stop in one cycle; the latches must outlive them
      sense.temp_shutdown = 1; sense.temp_warning = 1; sense.voltage_limit = 1;
      sense.current_limit = 1; tick(2); chk("stage", 8'h00, stage_on);
      sense = '0; sense.terminals_low = 1; sense.heating = 1;
      rd("status latched", OFF_STATUS, 8'hb3);
      wr(OFF_CONTROL, 8'h82); rd("status cleared", OFF_STATUS, 8'h80);
      wait_on(1); sense.vin_over = 1; tick(2); chk("stage", 8'h00, stage_on);
      sense.vin_over = 0; sense.vin_restart = 1; wait_on(1);
      sense.linear_leg_trip2 = 1; tick(2); chk("hiccup", 8'h00, stage_on);
      sense.linear_leg_trip2 = 0; wait_on(1); chk("check", 8'h01, check_on);
      sdn = 0; tick(2); chk("stage", 8'h00, stage_on);
      end_sim();
   end
endmodule : testbench
